/* File: verilog/sfpm_power_seq.sv */
// sfpm_power_seq: power-mode sequencer for a serial flash (active, standby, sleep).
// assumes the host keeps select/clock rules; busy comes from the embedded engine.

// Operation
// - Select low keeps the device active.
// - After select rises, stay active until program, erase or write work ends.
// - Enter opcode B9h with toggling clock moves standby toward deep power down.
// - Enter command is refused while write_in_progress is set.
// - In deep power down only release opcode or hardware reset act.
// - Deep power down begins after select rises and entry delay passes.
// - Release opcode ABh returns to standby after select rises and release delay.
module sfpm_power_seq (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial pins from host
  input wire logic chipSelect_n,
  input wire logic serialClk,
  input wire logic serialIn,
  // embedded engine status
  input wire logic programBusy,
  input wire logic eraseBusy,
  input wire logic writeBusy,
  input wire logic write_in_progress,
  // power state outputs
  output logic activeMode,
  output logic standbyMode,
  output logic deep_power_down,
  output logic sleepBusy
);

  sfpm_cmd_if cmdBus ();

  sfpm_opcode_shift shifter (
    .sys_clk(sys_clk),
    .rst(rst),
    .chipSelect_n(chipSelect_n),
    .serialClk(serialClk),
    .serialIn(serialIn),
    .cmd(cmdBus)
  );

  sfpm_pkg::sfpm_state_type state, next_state;
  logic [sfpm_pkg::DELAY_WIDTH-1:0] delayCount, next_delayCount;
  logic next_activeMode, next_standbyMode, next_sleep, next_sleepBusy;
  logic engineBusy;

  assign engineBusy = programBusy | eraseBusy | writeBusy | write_in_progress;

  // ***********************************
  // next-state logic
  // ***********************************
  always_comb begin
    next_state = state;
    next_delayCount = delayCount;
    unique case (state)
      sfpm_pkg::ST_ACTIVE: begin
        // leave only when deselected and all internal work done
        if (chipSelect_n && !engineBusy) begin
          next_state = sfpm_pkg::ST_STANDBY;
        end
        // any embedded work refuses the enter opcode, so active is never cut short
        if (cmdBus.cmdValid && cmdBus.cmdClocked && !engineBusy
            && cmdBus.cmdCode == sfpm_pkg::OP_ENTER_SLEEP) begin
          next_state = sfpm_pkg::ST_ENTERING;
          next_delayCount = sfpm_pkg::ENTRY_LOAD;
        end
      end
      sfpm_pkg::ST_STANDBY: begin
        if (!chipSelect_n) begin
          next_state = sfpm_pkg::ST_ACTIVE;
        end
        // frame end lands here: active has already dropped when select rose
        if (cmdBus.cmdValid && cmdBus.cmdClocked && !engineBusy
            && cmdBus.cmdCode == sfpm_pkg::OP_ENTER_SLEEP) begin
          next_state = sfpm_pkg::ST_ENTERING;
          next_delayCount = sfpm_pkg::ENTRY_LOAD;
        end
      end
      sfpm_pkg::ST_ENTERING: begin
        // select is high here; count down the entry delay
        if (delayCount <= 12'h001) begin
          next_state = sfpm_pkg::ST_SLEEP;
        end else begin
          next_delayCount = delayCount - 12'h001;
        end
      end
      sfpm_pkg::ST_SLEEP: begin
        // every other frame is ignored; stay asleep
        if (cmdBus.cmdValid && cmdBus.cmdClocked
            && cmdBus.cmdCode == sfpm_pkg::OP_RELEASE) begin
          next_state = sfpm_pkg::ST_RELEASING;
          next_delayCount = sfpm_pkg::RELEASE_LOAD;
        end
      end
      sfpm_pkg::ST_RELEASING: begin
        // host keeps select steady here, so no frame is tracked
        if (delayCount <= 12'h001) begin
          next_state = sfpm_pkg::ST_STANDBY;
        end else begin
          next_delayCount = delayCount - 12'h001;
        end
      end
      default: begin
        next_state = sfpm_pkg::ST_STANDBY;
      end
    endcase
    next_activeMode = (next_state == sfpm_pkg::ST_ACTIVE);
    next_standbyMode = (next_state == sfpm_pkg::ST_STANDBY);
    next_sleep = (next_state == sfpm_pkg::ST_SLEEP);
    next_sleepBusy = (next_state == sfpm_pkg::ST_ENTERING)
                     || (next_state == sfpm_pkg::ST_RELEASING);
  end

  // ***********************************
  // state registers
  // ***********************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= sfpm_pkg::ST_STANDBY;
      delayCount <= 12'h000;
      activeMode <= 1'b0;
      standbyMode <= 1'b1;
      deep_power_down <= 1'b0;
      sleepBusy <= 1'b0;
    end else begin
      state <= next_state;
      delayCount <= next_delayCount;
      activeMode <= next_activeMode;
      standbyMode <= next_standbyMode;
      deep_power_down <= next_sleep;
      sleepBusy <= next_sleepBusy;
    end
  end

endmodule // sfpm_power_seq

/* File: verilog/sfpm_pkg.sv */
// sfpm_pkg: shared constants and types for the flash power-mode sequencer.
// assumes a 100 MHz system clock; opcodes arrive msb first on the serial input.
package sfpm_pkg;

  // ***********************************
  // opcodes and timing
  // ***********************************
  localparam logic [7:0] OP_ENTER_SLEEP = 8'hB9;
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam int CLK_PERIOD_NS = 10;
  // entry and release delays are set elsewhere; plain defaults in ns
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int SLEEP_RELEASE_DELAY_NS = 3000;
  // least times round up to whole cycles
  localparam int ENTRY_CYCLES = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYCLES = (SLEEP_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_WIDTH = 12;
  localparam logic [DELAY_WIDTH-1:0] ENTRY_LOAD = 12'(ENTRY_CYCLES);
  localparam logic [DELAY_WIDTH-1:0] RELEASE_LOAD = 12'(RELEASE_CYCLES);

  // ***********************************
  // power states
  // ***********************************
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_STANDBY = 3'b001,
    ST_ENTERING = 3'b010,
    ST_SLEEP = 3'b011,
    ST_RELEASING = 3'b100
  } sfpm_state_type;

endpackage

/* File: verilog/sfpm_cmd_if.sv */
// sfpm_cmd_if: carries a decoded opcode from the shifter to the sequencer.
// assumes one clock domain; strobe is a one-cycle pulse.
interface sfpm_cmd_if;
  logic cmdValid;
  logic [7:0] cmdCode;
  logic cmdClocked;
  modport source (output cmdValid, output cmdCode, output cmdClocked);
  modport sink (input cmdValid, input cmdCode, input cmdClocked);
endinterface

/* File: verilog/sfpm_opcode_shift.sv */
// sfpm_opcode_shift: samples the serial input on rising serial-clock edges.
// assumes the serial clock is oversampled by sys_clk; pins are synchronous.
module sfpm_opcode_shift (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial pins
  input wire logic chipSelect_n,
  input wire logic serialClk,
  input wire logic serialIn,
  // decoded command
  sfpm_cmd_if.source cmd
);

  logic sckPrev, next_sckPrev;
  logic csPrev, next_csPrev;
  logic [7:0] shiftReg, next_shiftReg;
  logic [3:0] bitCount, next_bitCount;
  logic valid, next_valid;
  logic [7:0] code, next_code;
  logic clocked, next_clocked;

  // ***********************************
  // shift and frame end detection
  // ***********************************
  always_comb begin
    next_sckPrev = serialClk;
    next_csPrev = chipSelect_n;
    next_shiftReg = shiftReg;
    next_bitCount = bitCount;
    next_valid = 1'b0;
    next_code = code;
    next_clocked = clocked;
    if (!chipSelect_n && csPrev) begin
      next_bitCount = 4'h0;
      next_clocked = 1'b0;
    end else if (!chipSelect_n && serialClk && !sckPrev) begin
      next_clocked = 1'b1;
      if (bitCount < 4'h8) begin
        next_shiftReg = {shiftReg[6:0], serialIn}; // msb first
        next_bitCount = bitCount + 4'h1;
      end
    end
    // flag every select rise; the code is kept only after a whole opcode, else 00
    if (chipSelect_n && !csPrev) begin
      next_valid = 1'b1;
      next_code = (bitCount == 4'h8) ? shiftReg : 8'h00;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sckPrev <= 1'b0;
      csPrev <= 1'b1;
      shiftReg <= 8'h00;
      bitCount <= 4'h0;
      valid <= 1'b0;
      code <= 8'h00;
      clocked <= 1'b0;
    end else begin
      sckPrev <= next_sckPrev;
      csPrev <= next_csPrev;
      shiftReg <= next_shiftReg;
      bitCount <= next_bitCount;
      valid <= next_valid;
      code <= next_code;
      clocked <= next_clocked;
    end
  end

  assign cmd.cmdValid = valid;
  assign cmd.cmdCode = code;
  assign cmd.cmdClocked = clocked;

endmodule // sfpm_opcode_shift

/* File: verification/sfpm_host_model.sv */
// sfpm_host_model: host end of the select/serial link.
// assumes sys_clk oversamples the link; tb calls send() hierarchically.
module sfpm_host_model (
  // clock
  input wire logic sys_clk,
  // link pins
  output logic chipSelect_n,
  output logic serialClk,
  output logic serialIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: deselected, serial clock parked low
  initial begin
    chipSelect_n = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
  // one frame of nBits rising clocks, msb first; with nBits 0 the clock stays parked low
  task automatic send(input logic [7:0] code, input int nBits);
    @(posedge sys_clk) chipSelect_n <= 1'b0;
    for (int i = 0; i < nBits; i++) begin
      @(posedge sys_clk) serialIn <= code[7 - (i % 8)];
      @(posedge sys_clk) serialClk <= 1'b1;
      @(posedge sys_clk) serialClk <= 1'b0;
    end
    @(posedge sys_clk) chipSelect_n <= 1'b1;
    serialIn <= ~serialIn; // released line must not look held
  endtask
endmodule // sfpm_host_model

/* File: verification/sfpm_power_seq_monitor.sv */
// sfpm_power_seq_monitor: port checks for the power-mode sequencer.
// assumes one clock and the async high reset; bound to every instance.
module sfpm_power_seq_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // select and engine status
  input wire logic chipSelect_n,
  input wire logic programBusy,
  input wire logic eraseBusy,
  input wire logic writeBusy,
  input wire logic write_in_progress,
  // power state
  input wire logic activeMode,
  input wire logic standbyMode,
  input wire logic deep_power_down,
  input wire logic sleepBusy
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ENT_LO = sfpm_pkg::ENTRY_CYCLES - 1;
  localparam int ENT_HI = sfpm_pkg::ENTRY_CYCLES + 1;
  localparam int REL_LO = sfpm_pkg::RELEASE_CYCLES - 1;
  localparam int REL_HI = sfpm_pkg::RELEASE_CYCLES + 1;
  // any embedded work keeps the part awake
  wire logic busy = programBusy | eraseBusy | writeBusy | write_in_progress;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_sel_active;
    $fell(chipSelect_n) && standbyMode |-> ##2 activeMode;
  endproperty
  a_sel_active: assert property (p_sel_active) else $error("select low not active");
  property p_busy_hold;
    activeMode && chipSelect_n && busy && $past(busy) |=> activeMode;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("left active while busy");
  property p_enter_time;
    $rose(sleepBusy) && !$past(deep_power_down) |-> ##[ENT_LO:ENT_HI] deep_power_down;
  endproperty
  a_enter_time: assert property (p_enter_time) else $error("sleep entry late");
  property p_refuse;
    (activeMode && write_in_progress) [*2] |=> !sleepBusy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("enter taken while busy");
  property p_sleep_stay;
    deep_power_down |=> !activeMode && (deep_power_down || sleepBusy);
  endproperty
  a_sleep_stay: assert property (p_sleep_stay) else $error("sleep left wrongly");
  property p_enter_early;
    $rose(deep_power_down) |-> $past(sleepBusy, ENT_LO) && $past(sleepBusy);
  endproperty
  a_enter_early: assert property (p_enter_early) else $error("sleep entry early");
  property p_release;
    $rose(sleepBusy) && $past(deep_power_down) |-> ##[REL_LO:REL_HI] standbyMode;
  endproperty
  a_release: assert property (p_release) else $error("release time wrong");
  property p_after_sel;
    $rose(sleepBusy) |-> chipSelect_n && $past(chipSelect_n, 2);
  endproperty
  a_after_sel: assert property (p_after_sel) else $error("command before select high");
endmodule // sfpm_power_seq_monitor
bind sfpm_power_seq sfpm_power_seq_monitor i_mon (.sys_clk, .rst, .chipSelect_n, .programBusy,
  .eraseBusy, .writeBusy, .write_in_progress, .activeMode, .standbyMode, .deep_power_down,
  .sleepBusy);

/* File: verification/tb_sfpm_power_seq.sv */
// tb_sfpm_power_seq: self-checking bench for the power-mode sequencer.
// assumes the host model drives the link; busy inputs driven here.
module tb_sfpm_power_seq;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic programBusy = 1'b0, eraseBusy = 1'b0, writeBusy = 1'b0, write_in_progress = 1'b0;
  wire logic chipSelect_n, serialClk, serialIn;
  wire logic activeMode, standbyMode, deep_power_down, sleepBusy;
  wire logic [3:0] outs = {activeMode, standbyMode, deep_power_down, sleepBusy};
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  initial forever #5 sys_clk = ~sys_clk;
  sfpm_host_model i_sfpm_host_model (.sys_clk, .chipSelect_n, .serialClk, .serialIn);
  sfpm_power_seq i_sfpm_power_seq (.sys_clk, .rst, .chipSelect_n, .serialClk, .serialIn,
    .programBusy, .eraseBusy, .writeBusy, .write_in_progress, .activeMode, .standbyMode,
    .deep_power_down, .sleepBusy);
  task automatic check(input logic seen, input logic want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // bounded wait for one state output (3 active, 2 standby, 1 sleep, 0 delay)
  task automatic wait_out(input int b, input int limit);
    n = 0;
    while (outs[b] !== 1'b1 && n < limit) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // enter opcode under each busy source: stays active, refused, then standby
  task automatic t_busy;
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk) {programBusy, eraseBusy, writeBusy, write_in_progress} <= 4'h1 << k;
      i_sfpm_host_model.send(8'hB9, 8);
      repeat (5) @(posedge sys_clk);
      check(activeMode, 1'b1);
      @(posedge sys_clk) {programBusy, eraseBusy, writeBusy, write_in_progress} <= 4'h0;
      wait_out(2, 10);
      check(standbyMode, 1'b1);
      check(sleepBusy, 1'b0);
    end
  endtask
  // seven bits only: no command
  task automatic t_short;
    i_sfpm_host_model.send(8'hB9, 7);
    repeat (5) @(posedge sys_clk);
    check(sleepBusy, 1'b0);
  endtask
  task automatic t_enter;
    i_sfpm_host_model.send(8'hB9, 8);
    wait_out(0, 5);
    check(sleepBusy, 1'b1);
    wait_out(1, 400);
    check(n >= sfpm_pkg::ENTRY_CYCLES - 2, 1'b1);
  endtask
  // other opcode and an unclocked select cycle leave sleep alone
  task automatic t_ignore;
    i_sfpm_host_model.send(8'h05, 8);
    i_sfpm_host_model.send(8'hAB, 0);
    i_sfpm_host_model.send(8'hB9, 8);
    repeat (5) @(posedge sys_clk);
    check(deep_power_down, 1'b1);
    check(activeMode, 1'b0);
  endtask
  task automatic t_release;
    i_sfpm_host_model.send(8'hAB, 8);
    wait_out(0, 5);
    check(sleepBusy, 1'b1);
    wait_out(2, 400);
    check(standbyMode, 1'b1);
    check(n >= sfpm_pkg::RELEASE_CYCLES - 2, 1'b1);
    check(deep_power_down, 1'b0);
  endtask
  // main sequence, ending with a hardware reset out of sleep
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_busy();
    t_short();
    t_enter();
    t_ignore();
    t_release();
    t_enter();
    @(posedge sys_clk) rst <= 1'b1;
    @(posedge sys_clk) rst <= 1'b0;
    @(posedge sys_clk);
    check(standbyMode, 1'b1);
    check(deep_power_down, 1'b0);
    end_of_test();
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
endmodule // tb_sfpm_power_seq
